// ===== hdl/charger_fault_status.sv
// Supervisory fault, interrupt and status logic of the battery charger
//
// Functional notes
// - Nonzero four-bit threshold enables overcurrent watch; zero blocks overcurrent alerts.
// - Qualified overcurrent closes battery switch, raises two irqs, flags detail.
// - Overcurrent alert starts a timer; still present at expiry turns converter off.
// - Shutdown time select: 0 gives 6ms, 1 gives 100ms.
// - Debounce: limit change 30ms both, input 7ms, overvoltage 30ms, overcurrent 3.3ms.
// - Reverse power-limit rising edge qualified by 450us, falling immediate.
// - Forward mode: power good low while input sits inside its voltage window.
// - Reverse mode: power good low only while sourced output inside window.
// - Charge status released with no input, fault, standby or no-charge mode.
// - Status blinks 1Hz 50% while charging; held low in top-off and done.
// - Reverse mode runs when mode field is 0x0A or enable pin high.
// - Three-bit field selects sourced current limit, eight codes.
// - Current sense measures outflow in reverse mode, inflow otherwise.
// - Reverse irq flag, mask, live ok bit; detail latched until read.
// - Overload 37.5ms raises reverse irq, clears ok, detail 01.
// - Overload 60ms stops switching, restarts after 300ms off, repeating.
// - Output undervoltage stops switching, raises irq, clears ok, detail 00.
// - Output overvoltage stops switching, raises irq, clears ok, detail 10.
// - After undervoltage or overvoltage stop, retry after 300ms off.
// - Pin high enables reverse mode; else host writes 0x0A to mode.
// - Enable with input above lockout: discharge pulldown on, switching held off.
// - Interrupt output low while any unmasked flag is set.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "charger_fault_defines.svh"

module charger_fault_status #(
    parameter int T_OC_QUAL_CYC = `T_OC_QUAL_US * `CLK_MHZ,
    parameter int T_OCP_SHORT_CYC = `T_OCP_SHORT_US * `CLK_MHZ,
    parameter int T_OCP_LONG_CYC = `T_OCP_LONG_US * `CLK_MHZ,
    parameter int T_ICL_CYC = `T_ICL_US * `CLK_MHZ,
    parameter int T_VIN_CYC = `T_VIN_US * `CLK_MHZ,
    parameter int T_BATOV_CYC = `T_BATOV_US * `CLK_MHZ,
    parameter int T_PLIM_CYC = `T_PLIM_US * `CLK_MHZ,
    parameter int T_RILIM_CYC = `T_RILIM_US * `CLK_MHZ,
    parameter int T_RSTOP_CYC = `T_RSTOP_US * `CLK_MHZ,
    parameter int T_ROFF_CYC = `T_ROFF_US * `CLK_MHZ,
    parameter int T_BLINK_CYC = (`US_PER_S / `STAT_BLINK_HZ)
        * `STAT_DUTY_PCT / 100 * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic batt_current_above_i,
    input wire logic batt_overvoltage_i,
    input wire logic input_current_limit_active_i,
    input wire logic input_valid_i,
    input wire logic vin_above_uvlo_i,
    input wire logic vin_above_ovlo_i,
    input wire logic reverse_supply_enable_pin_i,
    input wire logic reverse_output_under_i,
    input wire logic reverse_output_over_i,
    input wire logic reverse_output_in_window_i,
    input wire logic reverse_overload_i,
    input wire logic reverse_pos_current_limit_i,
    input wire charger_fault_pkg::charge_phase_type charge_phase_i,
    output logic [3:0] batt_sys_overcurrent_threshold_o,
    output logic battery_switch_o,
    output logic dcdc_shutdown_o,
    output logic reverse_mode_o,
    output logic reverse_switching_o,
    output logic input_pulldown_o,
    output logic [2:0] reverse_current_limit_sel_o,
    output logic sense_outflow_o,
    output logic power_good_n_o,
    output logic power_good_oe_o,
    output logic charge_status_o,
    output logic charge_status_oe_o,
    output logic interrupt_out_n_o,
    output logic interrupt_out_oe_o
);

    // ====================
    // Register bus
    charger_fault_pkg::irq_vec_type flags_r, flags_nxt, mask_r, events;
    logic [7:0] cfg_r;
    logic [3:0] mode_r;
    logic [2:0] ilim_r;
    logic wr_cfg, wr_mode, wr_mask, rd_irq, rd_detail;

    assign wr_cfg = reg_wr_i && (reg_addr_i == `REG_CFG);
    assign wr_mode = reg_wr_i && (reg_addr_i == `REG_MODE);
    assign wr_mask = reg_wr_i && (reg_addr_i == `REG_MASK);
    assign rd_irq = reg_rd_i && (reg_addr_i == `REG_IRQ);
    assign rd_detail = reg_rd_i && (reg_addr_i == `REG_DETAIL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= `RST_CFG;
            mask_r <= `RST_MASK;
            mode_r <= `RST_MODE;
            ilim_r <= `RST_ILIM;
        end else begin
            if (wr_cfg) begin
                cfg_r <= reg_wdata_i;
            end
            if (wr_mask) begin
                mask_r <= {2'b00, reg_wdata_i[5:0]};
            end
            if (wr_mode) begin
                mode_r <= reg_wdata_i[`MODE_MSB:0];
                ilim_r <= reg_wdata_i[`MODE_ILIM_MSB:`MODE_ILIM_LSB];
            end
        end
    end

    logic [3:0] thr;
    logic ocp_sel, standby, rev_en;
    assign thr = cfg_r[`CFG_THR_MSB:0];
    assign ocp_sel = cfg_r[`CFG_SEL_BIT];
    assign standby = cfg_r[`CFG_STBY_BIT];
    assign rev_en = (mode_r == `MODE_REVERSE)
        || reverse_supply_enable_pin_i;

    // ====================
    // Debounce bank
    localparam int RISE[`DB_N] = '{T_ICL_CYC, T_VIN_CYC, T_BATOV_CYC,
        T_PLIM_CYC, T_OC_QUAL_CYC, T_RILIM_CYC, T_RSTOP_CYC};
    localparam int FALL[`DB_N] = '{T_ICL_CYC, 1, 1, 1, 1, 1, 1};

    charger_fault_pkg::rev_state_type state_r;
    logic [`DB_N-1:0] raw, filt, filt_d;

    assign raw[`DB_ICL] = input_current_limit_active_i;
    assign raw[`DB_VIN] = input_valid_i;
    assign raw[`DB_BATOV] = batt_overvoltage_i;
    assign raw[`DB_PLIM] = reverse_pos_current_limit_i && rev_en;
    assign raw[`DB_OC] = batt_current_above_i && (thr != 4'h0);
    assign raw[`DB_RILIM] = reverse_overload_i
        && (state_r == charger_fault_pkg::REV_RUN);
    // Gated by the run state so each restart re-qualifies the overload
    assign raw[`DB_RSTOP] = reverse_overload_i
        && (state_r == charger_fault_pkg::REV_RUN);

    for (genvar g = 0; g < `DB_N; g++) begin : g_db
        debounce_filter #(
            .RISE_CYC(RISE[g]),
            .FALL_CYC(FALL[g])
        ) u_db (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .raw_i(raw[g]),
            .filt_o(filt[g])
        );
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_d <= '0;
        end else begin
            filt_d <= filt;
        end
    end

    logic oc_ev, uv_ev, ov_ev, rilim_ev, running;
    assign running = (state_r == charger_fault_pkg::REV_RUN);
    assign oc_ev = filt[`DB_OC] && !filt_d[`DB_OC];
    assign rilim_ev = filt[`DB_RILIM] && !filt_d[`DB_RILIM];
    assign uv_ev = running && reverse_output_under_i;
    assign ov_ev = running && reverse_output_over_i;

    // ====================
    // Interrupt flags
    always_comb begin
        events = '0;
        events.batt_sys_overcurrent = oc_ev;
        events.battery = oc_ev
            || (filt[`DB_BATOV] && !filt_d[`DB_BATOV]);
        events.input_current_limit = filt[`DB_ICL] != filt_d[`DB_ICL];
        events.input_valid = filt[`DB_VIN] != filt_d[`DB_VIN];
        events.reverse_power_limit = filt[`DB_PLIM] && !filt_d[`DB_PLIM];
        events.reverse_supply = rilim_ev || uv_ev || ov_ev;
    end

    // New events win over the clearing read
    assign flags_nxt = (rd_irq ? '0 : flags_r) | events;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= '0;
            interrupt_out_oe_o <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            interrupt_out_oe_o <= |(flags_r & ~mask_r);
        end
    end

    assign interrupt_out_n_o = 1'b0;

    // ====================
    // Battery overcurrent shutdown timer
    logic [`CNT_W-1:0] ocp_cnt_r, ocp_lim;
    logic ocp_run_r, ocp_done, dcdc_off_r;
    assign ocp_lim = ocp_sel ? `CNT_W'(T_OCP_LONG_CYC - 1)
        : `CNT_W'(T_OCP_SHORT_CYC - 1);
    assign ocp_done = ocp_run_r && (ocp_cnt_r >= ocp_lim);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ocp_run_r <= 1'b0;
            ocp_cnt_r <= '0;
        end else if (oc_ev) begin
            ocp_run_r <= 1'b1;
            ocp_cnt_r <= '0;
        end else if (ocp_done) begin
            ocp_run_r <= 1'b0;
            ocp_cnt_r <= '0;
        end else if (ocp_run_r) begin
            ocp_cnt_r <= ocp_cnt_r + 1'b1;
        end
    end

    // Converter stays off until software rewrites the configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcdc_off_r <= 1'b0;
        end else if (ocp_done && filt[`DB_OC]) begin
            dcdc_off_r <= 1'b1;
        end else if (wr_cfg) begin
            dcdc_off_r <= 1'b0;
        end
    end

    // ====================
    // Reverse-supply sequencer
    logic [`CNT_W-1:0] off_cnt_r;
    logic off_done;
    assign off_done = off_cnt_r >= `CNT_W'(T_ROFF_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= charger_fault_pkg::REV_IDLE;
        end else if (!rev_en) begin
            state_r <= charger_fault_pkg::REV_IDLE;
        end else begin
            case (state_r)
                charger_fault_pkg::REV_IDLE: begin
                    if (vin_above_uvlo_i) begin
                        state_r <= charger_fault_pkg::REV_DISCHARGE;
                    end else begin
                        state_r <= charger_fault_pkg::REV_RUN;
                    end
                end
                charger_fault_pkg::REV_DISCHARGE: begin
                    if (!vin_above_uvlo_i) begin
                        state_r <= charger_fault_pkg::REV_RUN;
                    end
                end
                charger_fault_pkg::REV_RUN: begin
                    if (ov_ev || uv_ev || filt[`DB_RSTOP]) begin
                        state_r <= charger_fault_pkg::REV_OFF;
                    end
                end
                charger_fault_pkg::REV_OFF: begin
                    if (off_done) begin
                        state_r <= charger_fault_pkg::REV_RUN;
                    end
                end
                default: begin
                    state_r <= charger_fault_pkg::REV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != charger_fault_pkg::REV_OFF) begin
            off_cnt_r <= '0;
        end else if (!off_done) begin
            off_cnt_r <= off_cnt_r + 1'b1;
        end
    end

    // ====================
    // Reverse-supply status and latched detail
    logic rev_ok_r, det_lock_r;
    logic [1:0] rev_det_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rev_ok_r <= 1'b0;
        end else begin
            rev_ok_r <= running && !filt[`DB_RILIM] && !uv_ev && !ov_ev;
        end
    end

    // First fault is held; a fault coinciding with the read is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rev_det_r <= `REV_DET_NONE;
            det_lock_r <= 1'b0;
        end else if (events.reverse_supply && (!det_lock_r || rd_detail)) begin
            det_lock_r <= 1'b1;
            if (ov_ev) begin
                rev_det_r <= `REV_DET_OV;
            end else if (uv_ev) begin
                rev_det_r <= `REV_DET_UV;
            end else begin
                rev_det_r <= `REV_DET_ILIM;
            end
        end else if (rd_detail) begin
            det_lock_r <= 1'b0;
            rev_det_r <= `REV_DET_NONE;
        end
    end

    logic [2:0] bat_det;
    logic battery_ok_status;
    assign battery_ok_status = !filt[`DB_OC] && !filt[`DB_BATOV];
    assign bat_det = filt[`DB_OC] ? `BAT_DET_OC
        : (filt[`DB_BATOV] ? `BAT_DET_OV : `BAT_DET_OK);

    // ====================
    // Register read port
    always_ff @(posedge clk_i) begin
        if (rst_i || !reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `REG_IRQ: reg_rdata_o <= flags_r;
                `REG_MASK: reg_rdata_o <= mask_r;
                `REG_STATUS: reg_rdata_o <= {2'b00, dcdc_off_r,
                    filt[`DB_ICL], filt[`DB_VIN], rev_en, rev_ok_r, battery_ok_status};
                `REG_DETAIL: reg_rdata_o <= {2'b00, rev_det_r, 1'b0, bat_det};
                `REG_CFG: reg_rdata_o <= {2'b00, cfg_r[5:0]};
                `REG_MODE: reg_rdata_o <= {1'b0, ilim_r, mode_r};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ====================
    // Pin outputs
    logic blink_low, stat_hiz, stat_blink, stat_hold;
    assign stat_blink = (charge_phase_i == charger_fault_pkg::PH_TRICKLE)
        || (charge_phase_i == charger_fault_pkg::PH_PRECHARGE)
        || (charge_phase_i == charger_fault_pkg::PH_FAST);
    assign stat_hold = (charge_phase_i == charger_fault_pkg::PH_TOPOFF)
        || (charge_phase_i == charger_fault_pkg::PH_DONE);
    assign stat_hiz = !filt[`DB_VIN] || standby
        || (charge_phase_i == charger_fault_pkg::PH_FAULT)
        || (mode_r <= `MODE_NOCHG_MAX);

    status_blinker #(
        .HALF_CYC(T_BLINK_CYC)
    ) u_blink (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(stat_blink && !stat_hiz),
        .low_o(blink_low)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_good_oe_o <= 1'b0;
            charge_status_oe_o <= 1'b0;
            reverse_switching_o <= 1'b0;
            input_pulldown_o <= 1'b0;
        end else begin
            power_good_oe_o <= rev_en ? reverse_output_in_window_i
                : (vin_above_uvlo_i && !vin_above_ovlo_i);
            charge_status_oe_o <= !stat_hiz
                && (stat_hold || (stat_blink && blink_low));
            reverse_switching_o <= running && !dcdc_off_r;
            input_pulldown_o <= state_r == charger_fault_pkg::REV_DISCHARGE;
        end
    end

    assign power_good_n_o = 1'b0;
    assign charge_status_o = 1'b0;
    assign batt_sys_overcurrent_threshold_o = thr;
    assign battery_switch_o = filt[`DB_OC];
    assign dcdc_shutdown_o = dcdc_off_r;
    assign reverse_mode_o = rev_en;
    assign reverse_current_limit_sel_o = ilim_r;
    assign sense_outflow_o = rev_en;

    // ====================
    // Assertions
    thr_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (thr == 4'h0) [*3] |-> !oc_ev)
        else $error("overcurrent alert with feature disabled");

    oc_irqs_a: assert property (@(posedge clk_i) disable iff (rst_i)
        oc_ev |=> flags_r.batt_sys_overcurrent && flags_r.battery)
        else $error("overcurrent alert did not raise both flags");

    ocp_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ocp_done && filt[`DB_OC]) |=> dcdc_shutdown_o)
        else $error("converter not shut down at timer expiry");

    discharge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == charger_fault_pkg::REV_DISCHARGE) |=>
        input_pulldown_o && !reverse_switching_o)
        else $error("switching or no pulldown during discharge");

    uv_detail_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (uv_ev && !ov_ev && !det_lock_r) |=>
        rev_det_r == `REV_DET_UV && flags_r.reverse_supply && !rev_ok_r)
        else $error("undervoltage fault not reported");

    hiccup_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (running && $past(state_r) == charger_fault_pkg::REV_OFF && rev_en)
        |-> $past(off_cnt_r) == `CNT_W'(T_ROFF_CYC - 1))
        else $error("restart before off time elapsed");

    irq_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |(flags_r & ~mask_r) |=> interrupt_out_oe_o)
        else $error("interrupt pin idle with unmasked flag");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (flags_r.reverse_supply && !rd_irq) |=> flags_r.reverse_supply)
        else $error("flag dropped without a read");

    pg_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rev_en && vin_above_uvlo_i && !vin_above_ovlo_i) |=>
        power_good_oe_o)
        else $error("power good not driven with valid input");

    stat_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !filt[`DB_VIN] |=> !charge_status_oe_o)
        else $error("charge status driven without input");

endmodule

// ===== hdl/charger_fault_defines.svh
// Offsets, field positions, reset values and timing figures of the block
`ifndef CHARGER_FAULT_DEFINES_SVH
`define CHARGER_FAULT_DEFINES_SVH

// ====================
// Clock and counters
`define CLK_MHZ 20
`define CNT_W 24

// ====================
// Times in microseconds, blink rate in hertz, duty in percent
`define T_OC_QUAL_US 3300
`define T_OCP_SHORT_US 6000
`define T_OCP_LONG_US 100000
`define T_ICL_US 30000
`define T_VIN_US 7000
`define T_BATOV_US 30000
`define T_PLIM_US 450
`define T_RILIM_US 37500
`define T_RSTOP_US 60000
`define T_ROFF_US 300000
`define STAT_BLINK_HZ 1
`define STAT_DUTY_PCT 50
`define US_PER_S 1000000

// ====================
// Register offsets
`define REG_IRQ 4'h0
`define REG_MASK 4'h1
`define REG_STATUS 4'h2
`define REG_DETAIL 4'h3
`define REG_CFG 4'h4
`define REG_MODE 4'h5

// ====================
// Field positions and codes
`define CFG_THR_MSB 3
`define CFG_SEL_BIT 4
`define CFG_STBY_BIT 5
`define MODE_MSB 3
`define MODE_ILIM_LSB 4
`define MODE_ILIM_MSB 6
`define MODE_REVERSE 4'hA
`define MODE_NOCHG_MAX 4'h4
`define BAT_DET_OK 3'h3
`define BAT_DET_OV 3'h5
`define BAT_DET_OC 3'h6
`define REV_DET_UV 2'h0
`define REV_DET_ILIM 2'h1
`define REV_DET_OV 2'h2
`define REV_DET_NONE 2'h3

// ====================
// Reset values
`define RST_MASK 8'h3F
`define RST_CFG 8'h00
`define RST_MODE 4'h5
`define RST_ILIM 3'h0

// ====================
// Debounce channel indices
`define DB_ICL 0
`define DB_VIN 1
`define DB_BATOV 2
`define DB_PLIM 3
`define DB_OC 4
`define DB_RILIM 5
`define DB_RSTOP 6
`define DB_N 7

`endif

// ===== hdl/charger_fault_pkg.sv
// Types shared by the charger supervisory logic
package charger_fault_pkg;

    // ====================
    // Interrupt flag vector, also the mask layout
    typedef struct packed {
        logic [1:0] spare;
        logic reverse_supply;
        logic reverse_power_limit;
        logic input_valid;
        logic input_current_limit;
        logic battery;
        logic batt_sys_overcurrent;
    } irq_vec_type;

    // ====================
    // Reverse-supply sequencer states
    typedef enum logic [1:0] {
        REV_IDLE,
        REV_DISCHARGE,
        REV_RUN,
        REV_OFF
    } rev_state_type;

    // ====================
    // Charger phase reported by the charge state machine
    typedef enum logic [2:0] {
        PH_NO_INPUT,
        PH_IDLE,
        PH_TRICKLE,
        PH_PRECHARGE,
        PH_FAST,
        PH_TOPOFF,
        PH_DONE,
        PH_FAULT
    } charge_phase_type;

endpackage

// ===== hdl/debounce_filter.sv
// Edge-qualifying filter with separate rising and falling times
`timescale 1ns/1ps
`include "charger_fault_defines.svh"

module debounce_filter #(
    parameter int RISE_CYC = 1,
    parameter int FALL_CYC = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    output logic filt_o
);

    logic [`CNT_W-1:0] cnt_r;
    logic [`CNT_W-1:0] limit;

    assign limit = filt_o ? `CNT_W'(FALL_CYC - 1) : `CNT_W'(RISE_CYC - 1);

    // Any glitch back to the filtered level restarts qualification
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            filt_o <= 1'b0;
        end else if (raw_i == filt_o) begin
            cnt_r <= '0;
        end else if (cnt_r >= limit) begin
            cnt_r <= '0;
            filt_o <= raw_i;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule

// ===== hdl/status_blinker.sv
// Square-wave generator for the charge-status indicator
`timescale 1ns/1ps
`include "charger_fault_defines.svh"

module status_blinker #(
    parameter int HALF_CYC = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic low_o
);

    logic [`CNT_W-1:0] cnt_r;

    // Each blink starts with the low phase
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= '0;
            low_o <= 1'b1;
        end else if (cnt_r >= `CNT_W'(HALF_CYC - 1)) begin
            cnt_r <= '0;
            low_o <= !low_o;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule

// ===== tb/host_model.sv
// Host side of the open-drain indicator and interrupt lines
`timescale 1ns/1ps
module host_model (
    input wire logic pg_oe_i,
    input wire logic stat_oe_i,
    input wire logic irq_oe_i,
    output logic pg_lv_o,
    output logic stat_lv_o,
    output logic irq_lv_o
);
    // ====================
    // Pull-ups
    // Released lines go to the pull-up level, never hold the last value
    assign pg_lv_o = !pg_oe_i;
    assign stat_lv_o = !stat_oe_i;
    assign irq_lv_o = !irq_oe_i;
endmodule

// ===== tb/charger_fault_status_tb.sv
// Self-checking bench for the charger supervisory logic
`timescale 1ns/1ps
module charger_fault_status_tb;
    localparam int QUAL = 5;
    localparam int RIL = 8;
    localparam int ROFF = 30;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic batt_current_above_i = 1'b0;
    logic batt_overvoltage_i = 1'b0;
    logic input_current_limit_active_i = 1'b0;
    logic input_valid_i = 1'b1;
    logic vin_above_uvlo_i = 1'b0;
    logic vin_above_ovlo_i = 1'b0;
    logic reverse_supply_enable_pin_i = 1'b0;
    logic reverse_output_under_i = 1'b0;
    logic reverse_output_over_i = 1'b0;
    logic reverse_output_in_window_i = 1'b0;
    logic reverse_overload_i = 1'b0;
    logic reverse_pos_current_limit_i = 1'b0;
    charger_fault_pkg::charge_phase_type charge_phase_i =
        charger_fault_pkg::PH_IDLE;
    logic [7:0] reg_rdata_o, v;
    logic [2:0] reverse_current_limit_sel_o;
    logic [3:0] batt_sys_overcurrent_threshold_o;
    logic battery_switch_o, dcdc_shutdown_o, reverse_mode_o, sense_outflow_o;
    logic reverse_switching_o, input_pulldown_o, pg_lv, stat_lv, irq_lv;
    logic power_good_oe_o, charge_status_oe_o, interrupt_out_oe_o;
    logic power_good_n_o, charge_status_o, interrupt_out_n_o;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int lows = 0;
    // Address, value after reset, value written, value read back
    logic [31:0] rows [4] = '{32'h013F_FF3F, 32'h0400_FF3F, 32'h0505_FF7F,
        32'h0900_FF00};
    charger_fault_status #(.T_OC_QUAL_CYC(QUAL), .T_OCP_SHORT_CYC(20),
        .T_OCP_LONG_CYC(40), .T_ICL_CYC(10), .T_VIN_CYC(7),
        .T_BATOV_CYC(10), .T_PLIM_CYC(4), .T_RILIM_CYC(RIL),
        .T_RSTOP_CYC(12), .T_ROFF_CYC(ROFF), .T_BLINK_CYC(6))
        u_charger_fault_status (.*);
    host_model u_host_model (.pg_oe_i(power_good_oe_o),
        .stat_oe_i(charge_status_oe_o), .irq_oe_i(interrupt_out_oe_o),
        .pg_lv_o(pg_lv), .stat_lv_o(stat_lv), .irq_lv_o(irq_lv));
    // ====================
    // Clock, timeout and shared tasks
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
        @(posedge clk_i);
    endtask
    task automatic oc_run(input logic [7:0] cfg, input int t);
        wr(4'h4, cfg);
        batt_current_above_i <= 1'b1;
        w(QUAL + 4);
        chk1(battery_switch_o, 1'b1);
        chk1(irq_lv, 1'b0);
        chk8({4'h0, batt_sys_overcurrent_threshold_o}, cfg & 8'h0F);
        w(t - 6);
        chk1(dcdc_shutdown_o, 1'b0);
        w(8);
        chk1(dcdc_shutdown_o, 1'b1);
        rd(4'h0, v);
        chk8(v, 8'h03);
        batt_current_above_i <= 1'b0;
        wr(4'h4, 8'h00);
        chk1(dcdc_shutdown_o, 1'b0);
    endtask
    // ====================
    // Register rows, then hand-written cases
    initial begin
        w(12);
        rst_i <= 1'b0;
        w(1);
        foreach (rows[i]) begin
            rd(rows[i][27:24], v);
            chk8(v, rows[i][23:16]);
            wr(rows[i][27:24], rows[i][15:8]);
            rd(rows[i][27:24], v);
            chk8(v, rows[i][7:0]);
        end
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h05);
        wr(4'h1, 8'h3E);
        w(2);
        chk1(irq_lv, 1'b1);
        rd(4'h0, v);
        chk8(v, 8'h08);
        batt_current_above_i <= 1'b1;
        w(QUAL + 6);
        chk1(battery_switch_o, 1'b0);
        batt_current_above_i <= 1'b0;
        w(2);
        oc_run(8'h01, 20);
        oc_run(8'h11, 40);
        vin_above_uvlo_i <= 1'b1;
        wr(4'h5, 8'h3A);
        chk1(reverse_mode_o, 1'b1);
        chk1(sense_outflow_o, 1'b1);
        chk8({5'h00, reverse_current_limit_sel_o}, 8'h03);
        w(3);
        chk1(input_pulldown_o, 1'b1);
        chk1(reverse_switching_o, 1'b0);
        vin_above_uvlo_i <= 1'b0;
        reverse_output_in_window_i <= 1'b1;
        w(4);
        chk1(input_pulldown_o, 1'b0);
        chk1(reverse_switching_o, 1'b1);
        chk1(pg_lv, 1'b0);
        reverse_output_under_i <= 1'b1;
        reverse_pos_current_limit_i <= 1'b1;
        w(3);
        chk1(reverse_switching_o, 1'b0);
        reverse_output_under_i <= 1'b0;
        rd(4'h3, v);
        chk8(v & 8'h30, 8'h00);
        rd(4'h0, v);
        chk8(v, 8'h30);
        reverse_pos_current_limit_i <= 1'b0;
        w(ROFF - 8);
        chk1(reverse_switching_o, 1'b0);
        w(12);
        chk1(reverse_switching_o, 1'b1);
        reverse_overload_i <= 1'b1;
        w(RIL + 3);
        rd(4'h3, v);
        chk8(v & 8'h30, 8'h10);
        w(4);
        chk1(reverse_switching_o, 1'b0);
        w(ROFF + 4);
        chk1(reverse_switching_o, 1'b1);
        reverse_overload_i <= 1'b0;
        reverse_output_over_i <= 1'b1;
        w(3);
        chk1(reverse_switching_o, 1'b0);
        rd(4'h3, v);
        chk8(v & 8'h30, 8'h20);
        reverse_output_over_i <= 1'b0;
        wr(4'h5, 8'h05);
        reverse_supply_enable_pin_i <= 1'b1;
        w(2);
        chk1(reverse_mode_o, 1'b1);
        reverse_supply_enable_pin_i <= 1'b0;
        vin_above_uvlo_i <= 1'b1;
        w(3);
        chk1(pg_lv, 1'b0);
        vin_above_ovlo_i <= 1'b1;
        w(3);
        chk1(pg_lv, 1'b1);
        charge_phase_i <= charger_fault_pkg::PH_TOPOFF;
        w(3);
        chk1(stat_lv, 1'b0);
        charge_phase_i <= charger_fault_pkg::PH_FAST;
        w(3);
        repeat (24) begin
            @(negedge clk_i);
            if (stat_lv === 1'b0) lows++;
        end
        chk8(8'(lows), 8'h0C);
        w(1);
        wr(4'h4, 8'h20);
        w(3);
        chk1(stat_lv, 1'b1);
        input_valid_i <= 1'b0;
        wr(4'h4, 8'h00);
        w(2);
        chk1(stat_lv, 1'b1);
        chk1(power_good_n_o | charge_status_o | interrupt_out_n_o, 1'b0);
        print_verdict();
    end
endmodule
